/* hdl/serb_top.v */
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
// sense error record builder: wishbone slave that latches a record
module serb_top
(
    // clock and reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // wishbone slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output wire o_wb_ack,
    output reg [31:0] o_wb_dat,
    // record valid flag
    output reg o_rec_valid
);
`include "serb_defs.vh"

    ////////////////////////////////////////////////////////////////////////////
    reg [31:0] ctrl;
    reg [15:0] stat_in;
    reg [15:0] err_in;
    reg [15:0] cyl;
    reg [15:0] sect;
    reg [7:0] head;
    reg [31:0] rec0;
    reg [31:0] rec1;
    reg [31:0] rec2;
    reg ack;
    wire [7:0] reason;
    wire [47:0] loc;
    wire [3:0] key;
    wire [31:0] stat_merged;
    wire [31:0] err_merged;
    wire req;
    wire wr;
    integer i;

    assign key = ctrl[`SERB_CTRL_KEY_LSB +: 4];
    assign req = i_wb_cyc & i_wb_stb;
    assign wr = req & i_wb_we & ~ack;
    assign o_wb_ack = ack;

    // byte-lane merge for writes, used by ctrl, stat_in and err_in; cyl, sect and head ignore i_wb_sel
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (sel[k])
                    merge[k*8 +: 8] = dat[k*8 +: 8];
        end
    endfunction

    // location valid only for these keys
    function loc_ok;
        input [3:0] k;
        begin
            loc_ok = (k == `SERB_KEY_RECOVERED) || (k == `SERB_KEY_MEDIUM) ||
                (k == `SERB_KEY_HARDWARE);
        end
    endfunction

    // 16-bit input registers merged on a full word, upper half cut on purpose
    assign stat_merged = merge({16'h0000, stat_in}, i_wb_dat, i_wb_sel);
    assign err_merged = merge({16'h0000, err_in}, i_wb_dat, i_wb_sel);

    ////////////////////////////////////////////////////////////////////////////
    serb_reason u_reason
    (
        .i_sel(ctrl[`SERB_CTRL_REASON_LSB +: 3]),
        .o_code(reason)
    );

    serb_loc u_loc
    (
        .i_cyl(cyl),
        .i_head(head),
        .i_sect(sect),
        .i_ili(ctrl[`SERB_CTRL_ILI_BIT]),
        .i_head_unk(ctrl[`SERB_CTRL_HEAD_UNK_BIT]),
        .i_cyl_unk(ctrl[`SERB_CTRL_CYL_UNK_BIT]),
        .i_sect_unk(ctrl[`SERB_CTRL_SECT_UNK_BIT]),
        .i_irrel(ctrl[`SERB_CTRL_IRREL_BIT]),
        .o_loc(loc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle ack; dropped the cycle after so back-to-back needs a gap
    always @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // input registers written by firmware
    always @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ctrl <= `SERB_CTRL_RESET;
            stat_in <= 16'h0000;
            err_in <= 16'h0000;
            cyl <= 16'h0000;
            sect <= 16'h0000;
            head <= 8'h00;
        end
        else if (wr)
        begin
            case (i_wb_adr)
                `SERB_REG_CTRL: ctrl <= merge(ctrl, i_wb_dat, i_wb_sel);
                `SERB_REG_STAT_IN: stat_in <= stat_merged[15:0];
                `SERB_REG_ERR_IN: err_in <= err_merged[15:0];
                `SERB_REG_CYL: cyl <= i_wb_dat[15:0];
                `SERB_REG_SECT: sect <= i_wb_dat[15:0];
                `SERB_REG_HEAD: head <= i_wb_dat[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // record build: a write with the build bit set snapshots bytes 20..31.
    // snapshot means later input changes cannot tear a record being read.
    always @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rec0 <= 32'h00000000;
            rec1 <= 32'h00000000;
            rec2 <= 32'h00000000;
            o_rec_valid <= 1'b0;
        end
        else if (wr && i_wb_adr == `SERB_REG_CTRL && i_wb_sel[1] &&
            i_wb_dat[`SERB_CTRL_BUILD_BIT])
        begin
            o_rec_valid <= 1'b1;
            if (i_wb_dat[`SERB_CTRL_ALERT_BIT])
                rec0 <= {16'h0000, reason, 8'h00};
            else if (key == `SERB_KEY_MEDIUM || key == `SERB_KEY_HARDWARE)
            begin
                // byte 20 in bits 7:0, byte 23 in bits 31:24
                rec0[7:0] <= stat_in[7:0];
                rec0[15:8] <= stat_in[15:8];
                rec0[23:16] <= err_in[7:0] & `SERB_ERR22_MASK;
                rec0[31:24] <= err_in[15:8] & `SERB_ERR23_MASK;
            end
            else
                rec0 <= 32'h00000000;
            // byte 24 in bits 7:0 of rec1, bytes 28,29 in rec2
            for (i = 0; i < 4; i = i + 1)
                rec1[i*8 +: 8] <= loc_ok(key) ? loc[47-i*8 -: 8] : 8'h00;
            rec2[7:0] <= loc_ok(key) ? loc[15:8] : 8'h00;
            rec2[15:8] <= loc_ok(key) ? loc[7:0] : 8'h00;
            rec2[31:16] <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; only reads load it, so read data holds between reads.
    // unmapped reads zero. byte 23 bit0 is err_in bit 8; the direction bit is not used
    always @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_wb_dat <= 32'h00000000;
        else if (req & ~ack & ~i_wb_we)
        begin
            case (i_wb_adr)
                `SERB_REG_CTRL: o_wb_dat <= ctrl;
                `SERB_REG_STAT_IN: o_wb_dat <= {16'h0000, stat_in};
                `SERB_REG_ERR_IN: o_wb_dat <= {16'h0000, err_in};
                `SERB_REG_CYL: o_wb_dat <= {16'h0000, cyl};
                `SERB_REG_SECT: o_wb_dat <= {16'h0000, sect};
                `SERB_REG_HEAD: o_wb_dat <= {24'h000000, head};
                `SERB_REG_REC0: o_wb_dat <= rec0;
                `SERB_REG_REC1: o_wb_dat <= rec1;
                `SERB_REG_REC2: o_wb_dat <= rec2;
                default: o_wb_dat <= 32'h00000000;
            endcase
        end
    end
endmodule // serb_top

/* hdl/serb_defs.vh */
`ifndef SERB_DEFS_VH
`define SERB_DEFS_VH

// register word offsets (byte addresses)
`define SERB_REG_CTRL 8'h00
`define SERB_REG_STAT_IN 8'h04
`define SERB_REG_ERR_IN 8'h08
`define SERB_REG_CYL 8'h0C
`define SERB_REG_SECT 8'h10
`define SERB_REG_HEAD 8'h14
`define SERB_REG_REC0 8'h20
`define SERB_REG_REC1 8'h24
`define SERB_REG_REC2 8'h28
// control fields
`define SERB_CTRL_KEY_LSB 0
`define SERB_CTRL_ALERT_BIT 4
`define SERB_CTRL_ILI_BIT 5
`define SERB_CTRL_HEAD_UNK_BIT 6
`define SERB_CTRL_CYL_UNK_BIT 7
`define SERB_CTRL_SECT_UNK_BIT 8
`define SERB_CTRL_IRREL_BIT 9
`define SERB_CTRL_BUILD_BIT 10
`define SERB_CTRL_WRDIR_BIT 11
`define SERB_CTRL_REASON_LSB 12
`define SERB_CTRL_RESET 32'h00000000
// sense keys and alert
`define SERB_KEY_RECOVERED 4'h1
`define SERB_KEY_MEDIUM 4'h3
`define SERB_KEY_HARDWARE 4'h4
`define SERB_ASC_ALERT 8'h5D
// alert reasons (3-bit select -> code)
`define SERB_RSN_READ 8'h32
`define SERB_RSN_WRITE 8'h4A
`define SERB_RSN_SEEK 8'h43
`define SERB_RSN_SPARE 8'h14
`define SERB_RSN_LOAD 8'h50
`define SERB_RSN_SPIN 8'h56
`define SERB_RSN_RETRY 8'h5B
`define SERB_RSN_HOURS 8'h00
// valid bit masks of error bytes
`define SERB_ERR22_MASK 8'h05
`define SERB_ERR23_MASK 8'hF7
`define SERB_SECT_MAX_SHORT 16'h00FE
`define SERB_FILL 8'hFF
`endif

/* hdl/serb_reason.v */
`timescale 1ns/1ps
// maps an alert select to its reason code
module serb_reason
(
    // select
    input wire [2:0] i_sel,
    // code
    output reg [7:0] o_code
);
`include "serb_defs.vh"
    // table of codes, one per select
    always @*
    begin
        case (i_sel)
            3'h0: o_code = `SERB_RSN_READ;
            3'h1: o_code = `SERB_RSN_WRITE;
            3'h2: o_code = `SERB_RSN_SEEK;
            3'h3: o_code = `SERB_RSN_SPARE;
            3'h4: o_code = `SERB_RSN_LOAD;
            3'h5: o_code = `SERB_RSN_SPIN;
            3'h6: o_code = `SERB_RSN_RETRY;
            default: o_code = `SERB_RSN_HOURS;
        endcase
    end
endmodule // serb_reason

/* hdl/serb_loc.v */
`timescale 1ns/1ps
// forms location bytes 24..29 with fill rules
module serb_loc
(
    // inputs
    input wire [15:0] i_cyl,
    input wire [7:0] i_head,
    input wire [15:0] i_sect,
    input wire i_ili,
    input wire i_head_unk,
    input wire i_cyl_unk,
    input wire i_sect_unk,
    input wire i_irrel,
    // six bytes, byte 24 in the top
    output reg [47:0] o_loc
);
`include "serb_defs.vh"
    reg [7:0] b27;
    // irrelevant wins over unknown fills; ili wins over all
    always @*
    begin
        b27 = (i_sect > `SERB_SECT_MAX_SHORT) ? `SERB_FILL : i_sect[7:0];
        o_loc = {i_cyl, i_head, b27, i_sect};
        if (i_cyl_unk)
            o_loc[47:32] = {`SERB_FILL, `SERB_FILL};
        if (i_head_unk)
            o_loc[31:24] = `SERB_FILL;
        if (i_sect_unk)
            o_loc[23:0] = {`SERB_FILL, `SERB_FILL, `SERB_FILL};
        if (i_irrel)
            o_loc = {6{`SERB_FILL}};
        if (i_ili)
            o_loc = 48'h000000000000;
    end
endmodule // serb_loc

/* bench/serb_monitor.sv */
`timescale 1ns/1ps
// bus timing and record shape seen from the top ports
module serb_monitor
(
    // clock and reset
    input wire i_ref_clk,
    input wire i_sys_rst,
    // bus
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire o_wb_ack,
    input wire [31:0] o_wb_dat,
    input wire o_rec_valid
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_sys_rst);
////////////////////////////////////////////////////////////////////////////////
// answer one cycle after the request is taken
ack_on_time_a:
assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
ack_single_a:
assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
ack_cause_a:
assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc) && $past(i_wb_stb)) else $error("ack unasked");
// reserved bytes and unused error bits must read zero
rsvd_zero_a:
assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 8'h28
    |-> o_wb_dat[31:16] == 16'h0000) else $error("bytes 30/31 set");
unused_bits_a:
assert property (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 8'h20
    |-> (o_wb_dat[31:16] & 16'h08FA) == 16'h0000) else $error("unused error bit set");
// record valid only follows a build write and then stays; read data changes only with a read ack
valid_cause_a:
assert property ($rose(o_rec_valid) |-> $past(i_wb_cyc) && $past(i_wb_we)
    && $past(i_wb_adr) == 8'h00 && $past(i_wb_sel[1]) && $past(i_wb_dat[10]))
    else $error("valid without build");
valid_hold_a:
assert property (o_rec_valid |=> o_rec_valid) else $error("valid dropped");
rdata_hold_a:
assert property (!(o_wb_ack && !$past(i_wb_we)) |-> $stable(o_wb_dat)) else $error("rdata moved");
endmodule // serb_monitor

bind serb_top serb_monitor u_mon (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .o_rec_valid(o_rec_valid));

/* bench/serb_initiator.sv */
`timescale 1ns/1ps
// initiator side: classic single cycles that load and fetch the record
module serb_initiator
(
    // clock and answer
    input wire i_ref_clk,
    input wire i_wb_ack,
    input wire [31:0] i_wb_rdat,
    // request
    output reg o_wb_cyc,
    output reg o_wb_stb,
    output reg o_wb_we,
    output reg [7:0] o_wb_adr,
    output reg [3:0] o_wb_sel,
    output reg [31:0] o_wb_dat
);
initial
begin
    {o_wb_cyc, o_wb_stb, o_wb_we, o_wb_adr, o_wb_sel, o_wb_dat} = 47'h0;
end
// hold until ack is sampled; on release address and data show the inverse, not the old value
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_ref_clk);
    {o_wb_cyc, o_wb_stb, o_wb_we, o_wb_sel} <= {2'b11, w, 4'hF};
    {o_wb_adr, o_wb_dat} <= {a, d};
    do @(posedge i_ref_clk); while (i_wb_ack !== 1'b1);
    q = i_wb_rdat; // location words only trusted for keys 1,3,4
    {o_wb_cyc, o_wb_stb} <= 2'b00;
    {o_wb_adr, o_wb_dat} <= {~a, ~d};
endtask
endmodule // serb_initiator

/* bench/sense_error_record_builder_tb_top.sv */
`timescale 1ns/1ps
`include "serb_defs.vh"
`define SERB_CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module sense_error_record_builder_tb_top;
logic clk, rst, cyc, stb, we, ack, valid;
logic [7:0] adr, hd;
logic [3:0] sel;
logic [31:0] wdat, rdat, q, t;
logic [15:0] st, er, cy, se;
logic [14:0] c;
logic [95:0] e;
logic [3:0] keys [6] = '{4'h1, 4'h3, 4'h4, 4'h0, 4'h2, 4'hF};
logic [7:0] rsn [8] = '{`SERB_RSN_READ, `SERB_RSN_WRITE, `SERB_RSN_SEEK, `SERB_RSN_SPARE,
    `SERB_RSN_LOAD, `SERB_RSN_SPIN, `SERB_RSN_RETRY, `SERB_RSN_HOURS};
int num_errors = 0, n_checks = 0, cycles = 0;
serb_top uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_rec_valid(valid));
serb_initiator u_init (.i_ref_clk(clk), .i_wb_ack(ack), .i_wb_rdat(rdat), .o_wb_cyc(cyc),
    .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));
////////////////////////////////////////////////////////////////////////////////
// expected record bytes 20..31 from control and inputs
function automatic logic [95:0] exp_rec(input logic [14:0] k);
    logic [31:0] w0, w1, w2;
    logic [15:0] cl, sc;
    w0 = 32'h0;
    if (k[4]) w0 = {16'h0000, rsn[k[14:12]], 8'h00};
    else if (k[3:0] == 4'h3 || k[3:0] == 4'h4) w0 = {er & 16'hF705, st};
    cl = k[7] ? 16'hFFFF : cy;
    sc = k[8] ? 16'hFFFF : se;
    w1 = {(k[8] || se > 16'd254) ? 8'hFF : se[7:0], k[6] ? 8'hFF : hd,
        cl[7:0], cl[15:8]};
    w2 = {16'h0000, sc[7:0], sc[15:8]};
    if (k[9]) {w1, w2} = {32'hFFFFFFFF, 32'h0000FFFF};
    if (k[5] || !(k[3:0] inside {4'h1, 4'h3, 4'h4})) {w1, w2} = 64'h0;
    return {w2, w1, w0};
endfunction
task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// clock and hang guard
initial
begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
always @(posedge clk)
begin
    cycles++;
    if (cycles == 6000)
    begin
        num_errors++;
        final_report();
    end
end
// random records with sector 254/255, every reason code and sparse fill flags
initial
begin
    rst = 1'b1;
    void'($urandom(32'hBA47));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `SERB_CHK("valid idle", 1'b0, valid)
    for (int i = 0; i < 64; i++)
    begin
        {st, er, cy, se} = {$urandom, $urandom};
        hd = 8'($urandom);
        t = $urandom & $urandom;
        c = 15'($urandom);
        c[9:5] = t[4:0];
        c[3:0] = keys[$urandom_range(0, 5)];
        if (i < 8) {c[14:12], c[4]} = {3'(i), 1'b1};
        if (i % 4 == 1) se = 16'h00FE;
        if (i % 4 == 2) se = 16'h00FF;
        c[10] = 1'b0;
        u_init.xfer(1'b1, `SERB_REG_CYL, {16'h0000, cy}, q);
        u_init.xfer(1'b1, `SERB_REG_SECT, {16'h0000, se}, q);
        u_init.xfer(1'b1, `SERB_REG_HEAD, {24'h000000, hd}, q);
        u_init.xfer(1'b1, `SERB_REG_STAT_IN, {16'h0000, st}, q);
        u_init.xfer(1'b1, `SERB_REG_ERR_IN, {16'h0000, er}, q);
        u_init.xfer(1'b1, `SERB_REG_CTRL, {17'h0, c}, q);
        u_init.xfer(1'b1, `SERB_REG_CTRL, {17'h0, c} | 32'h00000400, q);
        e = exp_rec(c);
        for (int j = 0; j < 3; j++)
        begin
            u_init.xfer(1'b0, `SERB_REG_REC0 + 8'(4 * j), 32'h0, q);
            `SERB_CHK("rec", e[32*j +: 32], q)
        end
    end
    `SERB_CHK("valid built", 1'b1, valid)
    final_report();
end
endmodule // sense_error_record_builder_tb_top
